// [uci_pkg.sv]
// shared constants and carrier types for the serial control and status block
`default_nettype none

package uci_pkg;

	// ----------------------------------------------------------------
	// register map, byte addresses on the apb bus
	// ----------------------------------------------------------------
	localparam int         ADDR_W      = 8;
	localparam logic [7:0] ADDR_CTRL1  = 8'h00;
	localparam logic [7:0] ADDR_CTRL2  = 8'h04;
	localparam logic [7:0] ADDR_STAT1  = 8'h08;
	localparam logic [7:0] ADDR_DATA   = 8'h0C;

	// ----------------------------------------------------------------
	// reset values and masks
	// ----------------------------------------------------------------
	localparam logic [7:0]  CTRL1_RST  = 8'h00;
	localparam logic [7:0]  CTRL1_MASK = 8'hAE;
	localparam logic [7:0]  CTRL2_RST  = 8'h00;
	localparam logic [7:0]  DATA_RST   = 8'h00;
	localparam logic [23:0] RD_PAD     = 24'h000000;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int          CLK_PERIOD_NS   = 100;
	localparam int          BIT_TIME_NS     = 1600;
	localparam logic [15:0] BIT_CYCLES      = 16'(BIT_TIME_NS / CLK_PERIOD_NS);
	localparam logic [15:0] HALF_BIT_CYCLES = BIT_CYCLES >> 1;
	localparam logic [3:0]  FRAME_BITS      = 4'hA;
	localparam logic [3:0]  LONG_BREAK_BITS = 4'hD;
	localparam logic [3:0]  DATA_BITS       = 4'h8;
	localparam logic [15:0] IDLE_CYCLES     = 16'(int'(FRAME_BITS) * int'(BIT_CYCLES));
	localparam int          TX_SH_W         = 14;

	// ----------------------------------------------------------------
	// register layouts
	// ----------------------------------------------------------------
	typedef struct packed {
		logic tx_empty_irq_en;
		logic tx_done_irq_en;
		logic rx_full_irq_en;
		logic line_quiet_irq_en;
		logic tx_on;
		logic rx_on;
		logic rx_standby;
		logic send_break_bit;
	} uci_ctrl2_t;

	typedef struct packed {
		logic loop_select;
		logic rsvd6;
		logic rx_source_select;
		logic rsvd4;
		logic wake_select;
		logic long_break_select;
		logic single_wire_direction;
		logic rsvd0;
	} uci_ctrl1_t;

	typedef struct packed {
		logic       tx_buffer_empty_flag;
		logic       tx_done_flag;
		logic       rx_buffer_full_flag;
		logic       line_quiet_flag;
		logic       overrun_flag;
		logic [2:0] rsvd;
	} uci_status_t;

	typedef enum logic [1:0] {
		RX_WAIT  = 2'b00,
		RX_START = 2'b01,
		RX_BITS  = 2'b10,
		RX_STOP  = 2'b11
	} uci_rx_state_t;

endpackage

`default_nettype wire

// [uci_serial_ctl.sv]
// serial port control, status, transmit scheduling and receive wakeup logic
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module uci_serial_ctl
	import uci_pkg::*;
(
	// clock and reset
	input  wire logic              MCLK_I,
	input  wire logic              RESETN_I,
	// apb slave
	input  wire logic              PSEL_I,
	input  wire logic              PENABLE_I,
	input  wire logic              PWRITE_I,
	input  wire logic [ADDR_W-1:0] PADDR_I,
	input  wire logic [31:0]       PWDATA_I,
	output logic      [31:0]       PRDATA_O,
	output logic                   PREADY_O,
	output logic                   PSLVERR_O,
	// serial pins
	input  wire logic              TXD_I,
	output logic                   TXD_O,
	output logic                   TXD_OE_O,
	input  wire logic              RXD_I,
	output logic                   RXD_OWN_O,
	// interrupt request
	output logic                   IRQ_O
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	uci_ctrl1_t          ctrl1_q;
	uci_ctrl2_t          ctrl2_q;
	uci_ctrl2_t          ctrl2_d;
	uci_status_t         arm_q;
	uci_status_t         arm_d;
	uci_status_t         status;
	logic [31:0]         prdata_q;
	logic [7:0]          tx_buf_q;
	logic                tx_buffer_empty_flag_q;
	logic                tc_q;
	logic                tc_cond_q;
	logic                rx_buffer_full_flag_q;
	logic                idle_q;
	logic                ovr_q;
	logic                irq_q;
	logic                brk_pend_q;
	logic                idle_pend_q;
	logic                tx_busy_q;
	logic                tx_busy_d;
	logic [TX_SH_W-1:0]  tx_sh_q;
	logic [TX_SH_W-1:0]  tx_sh_d;
	logic [3:0]          tx_left_q;
	logic [3:0]          tx_left_d;
	logic [15:0]         tx_cnt_q;
	logic [15:0]         tx_cnt_d;
	uci_rx_state_t       rx_st_q;
	uci_rx_state_t       rx_st_d;
	logic [15:0]         rx_cnt_q;
	logic [15:0]         rx_cnt_d;
	logic [7:0]          rx_sh_q;
	logic [7:0]          rx_sh_d;
	logic [3:0]          rx_n_q;
	logic [3:0]          rx_n_d;
	logic [7:0]          rx_data_q;
	logic [15:0]         quiet_cnt_q;
	logic                quiet_armed_q;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	wire        acc     = PSEL_I & PENABLE_I;
	wire        setup   = PSEL_I & ~PENABLE_I;
	wire        sel_c1  = (PADDR_I == ADDR_CTRL1);
	wire        sel_c2  = (PADDR_I == ADDR_CTRL2);
	wire        sel_s1  = (PADDR_I == ADDR_STAT1);
	wire        sel_dat = (PADDR_I == ADDR_DATA);
	wire        mapped  = sel_c1 | sel_c2 | sel_s1 | sel_dat;
	wire        wr      = acc & PWRITE_I & mapped;
	wire        rd      = acc & ~PWRITE_I & mapped;
	wire [7:0]  wbyte   = PWDATA_I[7:0];
	wire uci_ctrl2_t wc2 = uci_ctrl2_t'(wbyte);

	wire wr_c1    = wr & sel_c1;
	wire wr_c2    = wr & sel_c2;
	wire wr_data  = wr & sel_dat;
	wire rd_stat  = rd & sel_s1;
	wire rd_data  = rd & sel_dat;
	wire te_rise  = wr_c2 & wc2.tx_on & ~ctrl2_q.tx_on;
	wire sbk_wr1  = wr_c2 & wc2.send_break_bit;
	wire sbk_rise = sbk_wr1 & ~ctrl2_q.send_break_bit;

	assign PREADY_O  = 1'b1;
	assign PSLVERR_O = acc & ~mapped;
	assign PRDATA_O  = prdata_q;

	// status write ignored: no write path reaches the flags
	assign status = '{tx_buffer_empty_flag: tx_buffer_empty_flag_q, tx_done_flag: tc_q,
	                  rx_buffer_full_flag: rx_buffer_full_flag_q, line_quiet_flag: idle_q,
	                  overrun_flag: ovr_q, rsvd: 3'h0};

	wire [7:0] rd_val = sel_c1  ? ctrl1_q :
	                    sel_c2  ? ctrl2_q :
	                    sel_s1  ? status :
	                    sel_dat ? rx_data_q : 8'h00;

	// ----------------------------------------------------------------
	// flag clear sequences: read status, then the qualifying access
	// ----------------------------------------------------------------
	wire clr_tx_buffer_empty_flag = wr_data & arm_q.tx_buffer_empty_flag;
	wire clr_tc   = (wr_data | te_rise | sbk_wr1) & arm_q.tx_done_flag;
	wire clr_rx_buffer_full_flag = rd_data & arm_q.rx_buffer_full_flag;
	wire clr_idle = rd_data & arm_q.line_quiet_flag;
	wire clr_ovr  = rd_data & arm_q.overrun_flag;

	always_comb
	begin
		arm_d = arm_q;
		if (rd_stat)
			arm_d = uci_status_t'(prdata_q[7:0]);
		else
		begin
			if (wr_data)
			begin
				arm_d.tx_buffer_empty_flag = 1'b0;
				arm_d.tx_done_flag         = 1'b0;
			end
			if (te_rise | sbk_wr1)
				arm_d.tx_done_flag = 1'b0;
			if (rd_data)
			begin
				arm_d.rx_buffer_full_flag = 1'b0;
				arm_d.line_quiet_flag     = 1'b0;
				arm_d.overrun_flag        = 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// line routing and pin ownership
	// ----------------------------------------------------------------
	wire tx_line    = tx_busy_q ? tx_sh_q[0] : 1'b1;
	wire single     = ctrl1_q.loop_select & ctrl1_q.rx_source_select;
	wire tx_owned   = ctrl2_q.tx_on | tx_busy_q | brk_pend_q | idle_pend_q;
	wire tx_hear    = single & ~ctrl1_q.single_wire_direction;
	wire rx_in      = ~ctrl1_q.loop_select ? RXD_I :
	                  (tx_hear ? TXD_I : tx_line);

	assign TXD_O     = tx_line;
	assign TXD_OE_O  = tx_owned & ~tx_hear;
	assign RXD_OWN_O = ctrl2_q.rx_on & ~ctrl1_q.loop_select;

	// ----------------------------------------------------------------
	// transmit scheduling: break, then idle, then data
	// ----------------------------------------------------------------
	wire brk_want  = brk_pend_q | (ctrl2_q.send_break_bit & ctrl2_q.tx_on);
	// next frame may start in the last bit cycle, so held breaks stay low with no gap
	wire free      = ~tx_busy_q | (tx_busy_q & (tx_cnt_q == 16'h0000) & (tx_left_q == 4'h1));
	wire go_brk    = free & brk_want;
	wire go_idle   = free & ~brk_want & idle_pend_q;
	wire go_data   = free & ~brk_want & ~idle_pend_q & ctrl2_q.tx_on & ~tx_buffer_empty_flag_q;
	wire tx_bit_end = tx_busy_q & (tx_cnt_q == 16'h0000);
	wire [3:0] brk_len = ctrl1_q.long_break_select ? LONG_BREAK_BITS : FRAME_BITS;
	wire tc_cond   = tx_buffer_empty_flag_q & ~tx_busy_q & ~brk_want & ~idle_pend_q;

	always_comb
	begin
		tx_busy_d = tx_busy_q;
		tx_sh_d   = tx_sh_q;
		tx_left_d = tx_left_q;
		tx_cnt_d  = tx_cnt_q;
		if (go_brk | go_idle | go_data)
		begin
			tx_busy_d = 1'b1;
			tx_cnt_d  = BIT_CYCLES - 16'h0001;
			tx_left_d = go_brk ? brk_len : FRAME_BITS;
			if (go_brk)
				tx_sh_d = '0;
			else if (go_idle)
				tx_sh_d = '1;
			else
				tx_sh_d = {4'hF, 1'b1, tx_buf_q, 1'b0};
		end
		else if (tx_bit_end)
		begin
			tx_cnt_d  = BIT_CYCLES - 16'h0001;
			tx_sh_d   = {1'b1, tx_sh_q[TX_SH_W-1:1]};
			tx_left_d = tx_left_q - 4'h1;
			if (tx_left_q == 4'h1)
				tx_busy_d = 1'b0;
		end
		else if (tx_busy_q)
			tx_cnt_d = tx_cnt_q - 16'h0001;
	end

	// ----------------------------------------------------------------
	// receiver
	// ----------------------------------------------------------------
	wire rx_run    = ctrl2_q.rx_on;
	wire rx_tick   = (rx_cnt_q == 16'h0000);
	wire frame_end = rx_run & (rx_st_q == RX_STOP) & rx_tick;
	wire standby   = ctrl2_q.rx_standby;
	wire am_wake   = frame_end & standby & ctrl1_q.wake_select & rx_sh_q[DATA_BITS-1];
	wire deliver   = frame_end & (~standby | am_wake);
	wire rx_buffer_full_flag_eff  = rx_buffer_full_flag_q & ~clr_rx_buffer_full_flag;
	wire rx_load   = deliver & ~rx_buffer_full_flag_eff;
	wire quiet_inc = rx_run & (rx_st_q == RX_WAIT) & rx_in & (quiet_cnt_q < IDLE_CYCLES);
	wire quiet_hit = quiet_inc & (quiet_cnt_q == IDLE_CYCLES - 16'h0001);
	wire il_wake   = quiet_hit & standby & ~ctrl1_q.wake_select;
	wire wake_evt  = am_wake | il_wake;
	wire idle_set  = quiet_hit & quiet_armed_q & ~standby;

	always_comb
	begin
		rx_st_d  = rx_st_q;
		rx_cnt_d = rx_tick ? 16'h0000 : rx_cnt_q - 16'h0001;
		rx_sh_d  = rx_sh_q;
		rx_n_d   = rx_n_q;
		case (rx_st_q)
			RX_WAIT:
			begin
				if (~rx_in)
				begin
					rx_st_d  = RX_START;
					rx_cnt_d = HALF_BIT_CYCLES - 16'h0001;
				end
			end
			RX_START:
			begin
				if (rx_tick)
				begin
					rx_st_d  = rx_in ? RX_WAIT : RX_BITS;
					rx_cnt_d = BIT_CYCLES - 16'h0001;
					rx_n_d   = 4'h0;
				end
			end
			RX_BITS:
			begin
				if (rx_tick)
				begin
					rx_sh_d  = {rx_in, rx_sh_q[7:1]};
					rx_cnt_d = BIT_CYCLES - 16'h0001;
					rx_n_d   = rx_n_q + 4'h1;
					if (rx_n_q == DATA_BITS - 4'h1)
						rx_st_d = RX_STOP;
				end
			end
			RX_STOP:
			begin
				if (rx_tick)
					rx_st_d = RX_WAIT;
			end
			default:
				rx_st_d = RX_WAIT;
		endcase
		if (~rx_run)
			rx_st_d = RX_WAIT;
	end

	// ----------------------------------------------------------------
	// control register next value
	// ----------------------------------------------------------------
	always_comb
	begin
		ctrl2_d = ctrl2_q;
		if (wr_c2)
			ctrl2_d = wc2;
		else if (wake_evt)
			ctrl2_d.rx_standby = 1'b0;
	end

	// ----------------------------------------------------------------
	// interrupt request
	// ----------------------------------------------------------------
	wire irq_d = (ctrl2_q.tx_empty_irq_en   & tx_buffer_empty_flag_q) |
	             (ctrl2_q.tx_done_irq_en    & tc_q)   |
	             (ctrl2_q.rx_full_irq_en    & rx_buffer_full_flag_q) |
	             (ctrl2_q.line_quiet_irq_en & idle_q);
	assign IRQ_O = irq_q;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK_I or negedge RESETN_I)
	begin
		if (~RESETN_I)
		begin
			ctrl1_q  <= uci_ctrl1_t'(CTRL1_RST);
			ctrl2_q  <= uci_ctrl2_t'(CTRL2_RST);
			arm_q    <= '0;
			prdata_q <= '0;
			tx_buf_q <= DATA_RST;
			irq_q    <= 1'b0;
		end
		else
		begin
			ctrl2_q <= ctrl2_d;
			arm_q   <= arm_d;
			irq_q   <= irq_d;
			if (wr_c1)
				ctrl1_q <= uci_ctrl1_t'(wbyte & CTRL1_MASK);
			if (wr_data)
				tx_buf_q <= wbyte;
			if (setup & ~PWRITE_I)
				prdata_q <= {RD_PAD, rd_val};
		end
	end

	// flags: a hardware set wins over a same-cycle clear
	always_ff @(posedge MCLK_I or negedge RESETN_I)
	begin
		if (~RESETN_I)
		begin
			tx_buffer_empty_flag_q      <= 1'b1;
			tc_q        <= 1'b1;
			tc_cond_q   <= 1'b1;
			rx_buffer_full_flag_q      <= 1'b0;
			idle_q      <= 1'b0;
			ovr_q       <= 1'b0;
			brk_pend_q  <= 1'b0;
			idle_pend_q <= 1'b0;
		end
		else
		begin
			tx_buffer_empty_flag_q      <= go_data | (tx_buffer_empty_flag_q & ~clr_tx_buffer_empty_flag);
			tc_cond_q   <= tc_cond;
			tc_q        <= (tc_cond & ~tc_cond_q) | (tc_q & ~clr_tc);
			rx_buffer_full_flag_q      <= rx_load | rx_buffer_full_flag_eff;
			idle_q      <= idle_set | (idle_q & ~clr_idle);
			ovr_q       <= (deliver & rx_buffer_full_flag_eff) | (ovr_q & ~clr_ovr);
			brk_pend_q  <= sbk_rise | (brk_pend_q & ~go_brk);
			idle_pend_q <= te_rise | (idle_pend_q & ~go_idle);
		end
	end

	always_ff @(posedge MCLK_I or negedge RESETN_I)
	begin
		if (~RESETN_I)
		begin
			tx_busy_q <= 1'b0;
			tx_sh_q   <= '1;
			tx_left_q <= 4'h0;
			tx_cnt_q  <= 16'h0000;
		end
		else
		begin
			tx_busy_q <= tx_busy_d;
			tx_sh_q   <= tx_sh_d;
			tx_left_q <= tx_left_d;
			tx_cnt_q  <= tx_cnt_d;
		end
	end

	always_ff @(posedge MCLK_I or negedge RESETN_I)
	begin
		if (~RESETN_I)
		begin
			rx_st_q       <= RX_WAIT;
			rx_cnt_q      <= 16'h0000;
			rx_sh_q       <= 8'h00;
			rx_n_q        <= 4'h0;
			rx_data_q     <= DATA_RST;
			quiet_cnt_q   <= 16'h0000;
			quiet_armed_q <= 1'b0;
		end
		else
		begin
			rx_st_q  <= rx_st_d;
			rx_cnt_q <= rx_cnt_d;
			rx_sh_q  <= rx_sh_d;
			rx_n_q   <= rx_n_d;
			if (rx_load)
				rx_data_q <= rx_sh_q;
			if (quiet_inc)
				quiet_cnt_q <= quiet_cnt_q + 16'h0001;
			else if (~(rx_run & (rx_st_q == RX_WAIT) & rx_in))
				quiet_cnt_q <= 16'h0000;
			if (rx_load)
				quiet_armed_q <= 1'b1;
			else if (idle_set)
				quiet_armed_q <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// [uci_serial_ctl_checker.sv]
// port assertions for the serial control and status block
`timescale 1ns/1ps
`default_nettype none

module uci_serial_ctl_checker
	import uci_pkg::*;
(
	// clock and reset
	input wire logic              MCLK_I,
	input wire logic              RESETN_I,
	// apb
	input wire logic              PSEL_I,
	input wire logic              PENABLE_I,
	input wire logic              PWRITE_I,
	input wire logic [ADDR_W-1:0] PADDR_I,
	input wire logic [31:0]       PWDATA_I,
	input wire logic [31:0]       PRDATA_O,
	input wire logic              PREADY_O,
	input wire logic              PSLVERR_O,
	// serial pins and request
	input wire logic              TXD_I,
	input wire logic              TXD_O,
	input wire logic              TXD_OE_O,
	input wire logic              RXD_I,
	input wire logic              RXD_OWN_O,
	input wire logic              IRQ_O
);
	// ----
	// shadow of control registers
	// ----
	uci_ctrl1_t c1_q;
	uci_ctrl2_t c2_q;
	wire logic  acc  = PSEL_I & PENABLE_I;
	wire logic  wr1  = acc & PWRITE_I & (PADDR_I == ADDR_CTRL1);
	wire logic  wr2  = acc & PWRITE_I & (PADDR_I == ADDR_CTRL2);
	wire logic  rd2  = acc & !PWRITE_I & (PADDR_I == ADDR_CTRL2);
	wire logic  bad  = acc & !(PADDR_I inside {ADDR_CTRL1, ADDR_CTRL2, ADDR_STAT1, ADDR_DATA});
	wire logic  swin = c1_q.loop_select & c1_q.rx_source_select & !c1_q.single_wire_direction;

	always_ff @(posedge MCLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			c1_q <= CTRL1_RST;
			c2_q <= CTRL2_RST;
		end
		else
		begin
			if (wr1)
				c1_q <= PWDATA_I[7:0] & CTRL1_MASK;
			if (wr2)
				c2_q <= PWDATA_I[7:0];
		end
	end

	// ----
	// properties
	// ----
	default clocking cb @(posedge MCLK_I);
	endclocking
	default disable iff (!RESETN_I);

	a_ready_high: assert property (PREADY_O) else $error("pready low");
	a_slverr_map: assert property (acc |-> PSLVERR_O == bad) else $error("pslverr wrong");
	a_ctrl2_read: assert property (rd2 |-> {PRDATA_O[7:2], PRDATA_O[0]} == {c2_q[7:2], c2_q[0]})
		else $error("control two read mismatch");
	a_irq_quiet: assert property (c2_q[7:4] == 4'h0 && $past(c2_q[7:4]) == 4'h0 |-> !IRQ_O)
		else $error("irq without enable");
	a_irq_cause: assert property ($rose(IRQ_O) |-> $past(c2_q[7:4]) != 4'h0)
		else $error("irq rose while all enables clear");
	a_tx_pin_on: assert property (c2_q.tx_on && !swin |-> TXD_OE_O) else $error("tx pin not driven");
	a_tx_pin_held: assert property (!c2_q.tx_on && !$past(TXD_OE_O) |-> !TXD_OE_O)
		else $error("tx pin taken while off");
	a_swin_recv: assert property (swin |-> !TXD_OE_O) else $error("single wire receive drives pin");
	a_rx_pin_own: assert property (RXD_OWN_O == (c2_q.rx_on & !c1_q.loop_select))
		else $error("rx pin ownership wrong");
	a_bit_low: assert property ($fell(TXD_O) |-> !TXD_O [*8] ##1 !TXD_O [*8])
		else $error("low level shorter than a bit");

	c_irq_up: cover property ($rose(IRQ_O));
	c_pin_drop: cover property ($fell(TXD_OE_O));
	c_bad_addr: cover property (bad);
endmodule

bind uci_serial_ctl uci_serial_ctl_checker i_chk (
	.MCLK_I, .RESETN_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I, .PRDATA_O,
	.PREADY_O, .PSLVERR_O, .TXD_I, .TXD_O, .TXD_OE_O, .RXD_I, .RXD_OWN_O, .IRQ_O
);

`default_nettype wire

// [uci_remote_node.sv]
// behavioural remote serial node on the transmit and receive lines
`timescale 1ns/1ps
`default_nettype none

module uci_remote_node
	import uci_pkg::*;
(
	// clock
	input  wire logic  clk_i,
	// serial lines
	input  wire logic  line_i,
	output logic       line_o,
	// observation
	output logic [7:0] byte_o,
	output int         bytes_o,
	output int         low_o
);
	int run_q;

	initial
	begin
		line_o  = 1'b1;
		byte_o  = 8'h00;
		bytes_o = 0;
		low_o   = 0;
		run_q   = 0;
	end

	// ----
	// low run meter, gives break length
	// ----
	always @(posedge clk_i)
	begin
		if (!line_i)
			run_q <= run_q + 1;
		else if (run_q != 0)
		begin
			low_o <= run_q;
			run_q <= 0;
		end
	end

	// ----
	// frame receiver, lsb first, mid-bit samples
	// ----
	always
	begin
		@(posedge clk_i iff !line_i);
		repeat (int'(HALF_BIT_CYCLES) - 1)
			@(posedge clk_i);
		for (int i = 0; i < 8; i++)
		begin
			repeat (int'(BIT_CYCLES))
				@(posedge clk_i);
			byte_o[i] = line_i;
		end
		repeat (int'(BIT_CYCLES))
			@(posedge clk_i);
		if (line_i)
			bytes_o = bytes_o + 1;
		@(posedge clk_i iff line_i);
	end

	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			@(posedge clk_i);
			line_o <= f[i];
			repeat (int'(BIT_CYCLES) - 1)
				@(posedge clk_i);
		end
	endtask
endmodule

`default_nettype wire

// [uci_tb.sv]
// self-checking bench for the serial control and status block
`timescale 1ns/1ps
`default_nettype none

module testbench
	import uci_pkg::*;
;
	logic              clk;
	logic              rst_n;
	logic              psel;
	logic              pen;
	logic              pwr;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic              txd;
	logic              txd_oe;
	logic              rxd;
	logic              rxd_own;
	logic              irq;
	logic [7:0]        nb;
	int                nbytes;
	int                nlow;
	logic [31:0]       rd;
	logic              er;
	int                bad_count;
	int                checks;
	wire logic         txd_pin = txd_oe ? txd : rxd;

	uci_serial_ctl i_dut (
		.MCLK_I    (clk),
		.RESETN_I  (rst_n),
		.PSEL_I    (psel),
		.PENABLE_I (pen),
		.PWRITE_I  (pwr),
		.PADDR_I   (paddr),
		.PWDATA_I  (pwdata),
		.PRDATA_O  (prdata),
		.PREADY_O  (pready),
		.PSLVERR_O (pslverr),
		.TXD_I     (txd_pin),
		.TXD_O     (txd),
		.TXD_OE_O  (txd_oe),
		.RXD_I     (rxd),
		.RXD_OWN_O (rxd_own),
		.IRQ_O     (irq)
	);

	uci_remote_node i_node (
		.clk_i   (clk),
		.line_i  (txd_pin),
		.line_o  (rxd),
		.byte_o  (nb),
		.bytes_o (nbytes),
		.low_o   (nlow)
	);

	initial
	begin
		clk = 1'b0;
		forever
			#50 clk = ~clk;
	end

	// ----
	// shared tasks
	// ----
	task automatic test_done();
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic hang();
		chk(32'h1, 32'h0);
		test_done();
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel   <= 1'b1;
		pwr    <= w;
		paddr  <= a;
		pwdata <= {24'h000000, d};
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
		begin
			n++;
			if (n > 20)
				hang();
			@(posedge clk);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		pen  <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask

	// expected value carries the error flag in bit 8
	task automatic rdc(input logic [7:0] a, input logic [8:0] e);
		apb(1'b0, a, 8'h00);
		chk({er, rd[30:0]}, {e[8], 23'h000000, e[7:0]});
	endtask

	// irq, tx pin drive, rx pin ownership
	task automatic pins(input logic [2:0] e);
		repeat (2)
			@(negedge clk);
		chk(32'({irq, txd_oe, rxd_own}), 32'(e));
	endtask

	task automatic poll(input logic [7:0] m, input logic [7:0] v);
		int n;
		n = 0;
		rd = 32'h0;
		while ((rd[7:0] & m) !== v)
		begin
			n++;
			if (n > 600)
				hang();
			apb(1'b0, ADDR_STAT1, 8'h00);
		end
	endtask

	task automatic node_byte(input int n, input logic [7:0] e);
		int k;
		k = 0;
		while (nbytes < n)
		begin
			k++;
			if (k > 2000)
				hang();
			@(posedge clk);
		end
		chk(32'(nb), 32'(e));
	endtask

	// ----
	// scenarios
	// ----
	task automatic t_regs();
		rdc(ADDR_CTRL2, 9'h000);
		rdc(ADDR_STAT1, 9'h0C0);
		wr(ADDR_STAT1, 8'h00);
		rdc(ADDR_STAT1, 9'h0C0);
		rdc(8'h10, 9'h100);
		wr(ADDR_CTRL1, 8'hFF);
		rdc(ADDR_CTRL1, {1'b0, CTRL1_MASK});
		wr(ADDR_CTRL1, 8'h00);
		wr(ADDR_CTRL2, 8'hF0);
		rdc(ADDR_CTRL2, 9'h0F0);
		for (int i = 0; i < 4; i++)
		begin
			wr(ADDR_CTRL2, 8'h80 >> i);
			pins({i < 2, 2'b00});
		end
		wr(ADDR_CTRL2, 8'h00);
		pins(3'b000);
		$display("t_regs finished");
	endtask

	task automatic t_tx();
		wr(ADDR_CTRL2, 8'h08);
		pins(3'b010);
		apb(1'b0, ADDR_STAT1, 8'h00);
		wr(ADDR_DATA, 8'h5A);
		rdc(ADDR_STAT1, 9'h000);
		poll(8'h80, 8'h80);
		node_byte(1, 8'h5A);
		wr(ADDR_DATA, 8'hA3);
		poll(8'h80, 8'h80);
		wr(ADDR_CTRL2, 8'h00);
		pins(3'b010);
		node_byte(2, 8'hA3);
		poll(8'h40, 8'h40);
		pins(3'b000);
		$display("t_tx finished");
	endtask

	task automatic t_break();
		int u;
		int lo;
		wr(ADDR_CTRL2, 8'h08);
		for (int i = 0; i < 3; i++)
		begin
			u  = int'(i == 1 ? LONG_BREAK_BITS : FRAME_BITS) * int'(BIT_CYCLES);
			lo = (i == 2) ? 3 : 1;
			wr(ADDR_CTRL1, (i == 1) ? 8'h04 : 8'h00);
			poll(8'h40, 8'h40);
			wr(ADDR_CTRL2, 8'h09);
			rdc(ADDR_STAT1, 9'h080);
			repeat ((i == 2) ? 400 : 0)
				@(posedge clk);
			wr(ADDR_CTRL2, 8'h08);
			poll(8'h40, 8'h40);
			chk(32'(nlow % u == 0 && nlow / u >= lo && nlow / u <= lo + 1), 32'h1);
		end
		$display("t_break finished");
	endtask

	task automatic t_rx();
		wr(ADDR_CTRL1, 8'h08);
		wr(ADDR_CTRL2, 8'h24);
		pins(3'b001);
		i_node.send(8'h11);
		poll(8'h20, 8'h20);
		pins(3'b101);
		rdc(ADDR_DATA, 9'h011);
		wr(ADDR_CTRL2, 8'h14);
		poll(8'h10, 8'h10);
		pins(3'b101);
		rdc(ADDR_DATA, 9'h011);
		pins(3'b001);
		wr(ADDR_CTRL2, 8'h26);
		i_node.send(8'h22);
		rdc(ADDR_CTRL2, 9'h026);
		rdc(ADDR_STAT1, 9'h0C0);
		i_node.send(8'h93);
		poll(8'h20, 8'h20);
		rdc(ADDR_CTRL2, 9'h024);
		rdc(ADDR_DATA, 9'h093);
		wr(ADDR_CTRL1, 8'h00);
		wr(ADDR_CTRL2, 8'h26);
		repeat (200)
			@(posedge clk);
		rdc(ADDR_CTRL2, 9'h024);
		$display("t_rx finished");
	endtask

	task automatic t_loop();
		wr(ADDR_CTRL1, 8'h80);
		wr(ADDR_CTRL2, 8'h0C);
		pins(3'b010);
		apb(1'b0, ADDR_STAT1, 8'h00);
		wr(ADDR_DATA, 8'h6B);
		poll(8'h20, 8'h20);
		rdc(ADDR_DATA, 9'h06B);
		wr(ADDR_CTRL1, 8'hA0);
		pins(3'b000);
		i_node.send(8'h4D);
		poll(8'h20, 8'h20);
		rdc(ADDR_DATA, 9'h04D);
		wr(ADDR_CTRL1, 8'hA2);
		pins(3'b010);
		$display("t_loop finished");
	endtask

	initial
	begin
		rst_n     = 1'b0;
		psel      = 1'b0;
		pen       = 1'b0;
		pwr       = 1'b0;
		paddr     = 8'h00;
		pwdata    = 32'h0;
		rd        = 32'h0;
		er        = 1'b0;
		bad_count = 0;
		checks    = 0;
		repeat (10)
			@(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_tx();
		t_break();
		t_rx();
		t_loop();
		test_done();
	end
endmodule

`default_nettype wire
